/* rtl/dsi_exec_unit.sv */
// Purpose: executes a subset of fixed-point dsp cpu operations
// Assumes: operands arrive from same-clock logic; port pins are asynchronous
// Notes:   one operation at a time, handshake on op_valid_i/op_ready_o
// Contract
// RL1: enable-interrupts clears the global interrupt mask to 0.
// RL2: maskable interrupts are accepted right after enable-interrupts, no delay slot.
// RL3: swap exchanges main accumulator and buffer in one operation.
// RL4: format loads the word-format bit; 0 means 16-bit words, 1 bytes.
// RL5: idle halts execution until reset or an interrupt.
// RL6: low-power halt removes the functional clock until reset or unmasked interrupt.
// RL7: port input reads one 16-bit port value into the addressed data word.
// RL8: on the earliest generation port input takes exactly two machine cycles.
// RL9: earliest generation drives port on three address lines with data strobe low.
// RL10: later generations drive io select low with read timing extended by ready.
// RL11: software vector takes K from 0 to 31 and jumps to its vector.
// RL12: vectors are two addresses apart, so the target is twice K.
// RL13: load shifted zero-fills low bits and sign-extends high bits when mode is 1.
// RL14: with sign-extension mode 0 the high bits fill with zeros.
`timescale 1ns/100ps
module dsi_exec_unit
  import dsi_pkg::*;
#(
  parameter int MC_CLKS = MACH_CYCLE_CLKS
) (
  // clock, reset, enable
  input  wire logic                 sys_clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 ce_i,
  // operation request
  input  wire logic                 op_valid_i,
  input  wire dsi_op_t              op_i,
  output logic                      op_ready_o,
  input  wire logic                 later_gen_i,
  input  wire logic                 sign_extension_mode_bit_i,
  input  wire logic [DATA_W-1:0]    dm_rdata_i,
  // interrupts
  input  wire logic                 irq_i,
  output logic                      int_ack_o,
  output logic                      global_interrupt_mask_o,
  // cpu state
  output logic [ACCUM_W-1:0]        main_accumulator_o,
  output logic [ACCUM_W-1:0]        accumulator_buffer_o,
  output logic                      serial_word_format_bit_o,
  output logic                      halted_o,
  output logic                      func_clk_en_o,
  output logic                      pc_load_o,
  output logic [PC_W-1:0]           pc_target_o,
  // data memory write
  output logic                      dm_we_o,
  output logic [15:0]               dm_addr_o,
  output logic [DATA_W-1:0]         dm_wdata_o,
  // external io port pins
  output dsi_io_bus_t               io_bus_o,
  input  wire logic [DATA_W-1:0]    port_data_i,
  input  wire logic                 ready_i
);

  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE,
    ST_LOW_POWER,
    ST_STROBE,
    ST_DATA
  } dsi_state_t;

  localparam int CNT_W = $clog2(MC_CLKS + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MC_CLKS - 1);
  localparam logic [CNT_W-1:0] CNT_CAP  = CNT_W'(CAPTURE_CLK);
  localparam int IOC_W = $clog2(4 * MC_CLKS + 2);

  dsi_state_t                state_q;
  dsi_state_t                state_d;
  logic [CNT_W-1:0]          cnt_q;
  logic                      mask_q;
  logic                      fmt_q;
  logic [ACCUM_W-1:0]        accum_q;
  logic [ACCUM_W-1:0]        buf_q;
  logic                      pc_load_q;
  logic [PC_W-1:0]           pc_target_q;
  logic                      gen_q;
  logic [LATE_PORT_BITS-1:0] port_q;
  logic [15:0]               dm_addr_q;
  logic [DATA_W-1:0]         dm_wdata_q;
  logic                      dm_we_q;
  dsi_io_bus_t               io_q;
  dsi_io_bus_t               io_d;
  logic [DATA_W-1:0]         pdata_m_q;
  logic [DATA_W-1:0]         pdata_s_q;
  logic                      rdy_m_q;
  logic                      rdy_s_q;
  logic [IOC_W-1:0]          io_clks_q;

  // pins are asynchronous to sys_clk_i: two flops before any use
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pdata_m_q <= RST_DATA;
      pdata_s_q <= RST_DATA;
      rdy_m_q   <= 1'b0;
      rdy_s_q   <= 1'b0;
    end else if (ce_i) begin
      pdata_m_q <= port_data_i;
      pdata_s_q <= pdata_m_q;
      rdy_m_q   <= ready_i;
      rdy_s_q   <= rdy_m_q;
    end
  end

  // decode
  wire in_run      = (state_q == ST_RUN);
  wire in_idle     = (state_q == ST_IDLE);
  wire in_lp       = (state_q == ST_LOW_POWER);
  wire in_strobe   = (state_q == ST_STROBE);
  wire in_data     = (state_q == ST_DATA);
  wire cnt_last    = (cnt_q == CNT_LAST);
  wire unmasked    = irq_i && !mask_q;
  // idle wakes on any interrupt, low-power halt only on an unmasked one
  wire wake_idle   = irq_i;                                              // [RL5]
  wire wake_lp     = unmasked;                                           // [RL6]
  // mask is read straight from its flop, so acceptance follows enable at once
  wire int_take    = ce_i && unmasked && (in_run || in_idle || in_lp);  // [RL2]
  wire op_fire     = ce_i && op_valid_i && op_ready_o;
  wire fire_en     = op_fire && (op_i.opcode == OP_ENABLE_INT);
  wire fire_dis    = op_fire && (op_i.opcode == OP_DISABLE_INT);
  wire fire_swap   = op_fire && (op_i.opcode == OP_SWAP);
  wire fire_fmt    = op_fire && (op_i.opcode == OP_FORMAT);
  wire fire_idle   = op_fire && (op_i.opcode == OP_IDLE);
  wire fire_lp     = op_fire && (op_i.opcode == OP_LOW_POWER_HALT);
  wire fire_in     = op_fire && (op_i.opcode == OP_PORT_IN);
  wire fire_vec    = op_fire && (op_i.opcode == OP_SOFT_VECTOR);
  wire fire_load   = op_fire && (op_i.opcode == OP_LOAD_SHIFTED);
  wire fire_frombuf = op_fire && (op_i.opcode == OP_LOAD_FROM_BUFFER);
  // later generations hold the strobe until the peripheral signals ready;
  // ready arrives two flops late, so a machine cycle under three clocks misses waits
  wire strobe_done = cnt_last && (!gen_q || rdy_s_q);                    // [RL10]
  wire gen_sel     = fire_in ? later_gen_i : gen_q;
  wire [LATE_PORT_BITS-1:0] port_sel = fire_in ? op_i.port_number : port_q;

  // load shifted: extend by mode, then shift left with zero fill
  wire [DATA_W-1:0]  ext_hi     = sign_extension_mode_bit_i ? {DATA_W{dm_rdata_i[DATA_W-1]}}
                                                           : {DATA_W{1'b0}};  // [RL13] [RL14]
  wire [ACCUM_W-1:0] ld_ext     = {ext_hi, dm_rdata_i};
  wire [ACCUM_W-1:0] ld_shifted = ld_ext << op_i.shift;                  // [RL13]

  // vectors sit two words apart, target = 2*K
  wire [PC_W-1:0] vec_addr = {{(PC_W - 6){1'b0}}, op_i.vec_k, 1'b0};     // [RL11] [RL12]

  assign op_ready_o = in_run && !int_take;
  assign int_ack_o  = int_take;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (fire_idle) begin
          state_d = ST_IDLE;                                             // [RL5]
        end else if (fire_lp) begin
          state_d = ST_LOW_POWER;                                        // [RL6]
        end else if (fire_in) begin
          state_d = ST_STROBE;                                           // [RL7]
        end
      end
      ST_IDLE: begin
        if (wake_idle) begin
          state_d = ST_RUN;
        end
      end
      ST_LOW_POWER: begin
        if (wake_lp) begin
          state_d = ST_RUN;
        end
      end
      ST_STROBE: begin
        if (strobe_done) begin
          state_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (cnt_last) begin
          state_d = ST_RUN;                                              // [RL8]
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // pin pattern for the coming clock, registered so the pins never glitch
  always_comb begin
    io_d = IO_QUIET;
    if (state_d == ST_STROBE) begin
      if (gen_sel) begin
        io_d.addr                     = {12'h000, port_sel};
        io_d.io_space_select_n        = 1'b0;                            // [RL10]
        io_d.external_access_strobe_n = 1'b0;
        io_d.read_n                   = 1'b0;
      end else begin
        io_d.addr                 = {13'h0000, port_sel[EARLY_PORT_BITS-1:0]};  // [RL9]
        io_d.data_enable_strobe_n = 1'b0;                                // [RL9]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_RUN;
      cnt_q   <= '0;
      io_q    <= IO_QUIET;
    end else if (ce_i) begin
      state_q <= state_d;
      io_q    <= io_d;
      if (state_d != state_q) begin
        cnt_q <= '0;
      end else if (!cnt_last) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // port input transfer bookkeeping
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gen_q      <= 1'b0;
      port_q     <= '0;
      dm_addr_q  <= 16'h0000;
      dm_wdata_q <= RST_DATA;
      dm_we_q    <= 1'b0;
    end else if (ce_i) begin
      gen_q   <= gen_sel;
      port_q  <= port_sel;
      dm_we_q <= in_data && cnt_last;                                    // [RL7]
      if (fire_in) begin
        dm_addr_q <= op_i.dm_addr;
      end
      // peripheral data seen through the synchroniser's second stage only
      if (in_data && (cnt_q == CNT_CAP)) begin
        dm_wdata_q <= pdata_s_q;                                         // [RL7]
      end
    end
  end

  // interrupt mask: taking an interrupt masks further ones
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_q <= RST_MASK;
    end else if (ce_i) begin
      if (int_take || fire_dis) begin
        mask_q <= 1'b1;
      end else if (fire_en) begin
        mask_q <= 1'b0;                                                  // [RL1]
      end
    end
  end

  // accumulator pair and format bit
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      accum_q <= RST_ACCUM;
      buf_q   <= RST_ACCUM;
      fmt_q   <= RST_FORMAT;
    end else if (ce_i) begin
      if (fire_swap) begin
        accum_q <= buf_q;                                                // [RL3]
        buf_q   <= accum_q;                                              // [RL3]
      end else if (fire_load) begin
        accum_q <= ld_shifted;                                           // [RL13]
      end else if (fire_frombuf) begin
        accum_q <= buf_q;
      end
      if (fire_fmt) begin
        fmt_q <= op_i.fmt_bit;                                           // [RL4]
      end
    end
  end

  // program-control redirect
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc_load_q   <= 1'b0;
      pc_target_q <= RST_PC;
    end else if (ce_i) begin
      pc_load_q <= fire_vec;
      if (fire_vec) begin
        pc_target_q <= vec_addr;                                         // [RL11] [RL12]
      end
    end
  end

  // helper count of transfer clocks, read only by the checks below
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_clks_q <= '0;
    end else if (ce_i) begin
      io_clks_q <= (in_strobe || in_data) ? io_clks_q + 1'b1 : '0;
    end
  end

  assign global_interrupt_mask_o  = mask_q;
  assign main_accumulator_o       = accum_q;
  assign accumulator_buffer_o     = buf_q;
  assign serial_word_format_bit_o = fmt_q;
  assign halted_o                 = in_idle || in_lp;
  // functional clock gate; the clock tree owner must hold it off while low
  assign func_clk_en_o            = !in_lp;                              // [RL6]
  assign pc_load_o                = pc_load_q;
  assign pc_target_o              = pc_target_q;
  assign dm_we_o                  = dm_we_q;
  assign dm_addr_o                = dm_addr_q;
  assign dm_wdata_o               = dm_wdata_q;
  assign io_bus_o                 = io_q;

  enable_interrupts_op_clears_mask_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL1]
    fire_en |=> !mask_q)
    else $error("mask not cleared by enable");

  enable_interrupts_op_accept_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL2]
    fire_en ##1 (ce_i && irq_i && in_run) |-> int_ack_o && !op_ready_o)
    else $error("interrupt not accepted right after enable");

  swap_exchange_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL3]
    fire_swap |=> (accum_q == $past(buf_q)) && (buf_q == $past(accum_q)))
    else $error("accumulator swap wrong");

  format_bit_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL4]
    fire_fmt |=> (serial_word_format_bit_o == $past(op_i.fmt_bit)))
    else $error("format bit not loaded");

  idle_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL5]
    (in_idle && !irq_i) |=> halted_o && !op_ready_o)
    else $error("idle left without interrupt");

  low_power_clk_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL6]
    (fire_lp ##1 !unmasked) |-> !func_clk_en_o ##1 !func_clk_en_o)
    else $error("functional clock not removed");

  port_write_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL7]
    (ce_i && in_data && (cnt_q == CNT_CAP)) |=> (dm_wdata_o == $past(pdata_s_q)))
    else $error("port data not captured");

  early_two_cycles_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL8]
    ($rose(dm_we_o) && !gen_q) |-> (io_clks_q == IOC_W'(2 * MC_CLKS)))
    else $error("early port input not two machine cycles");

  early_strobe_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL9]
    (in_strobe && !gen_q) |-> !io_bus_o.data_enable_strobe_n && io_bus_o.io_space_select_n
                              && (io_bus_o.addr[15:EARLY_PORT_BITS] == '0))
    else $error("early strobe or port address wrong");

  late_select_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL10]
    (in_strobe && gen_q && ce_i && cnt_last && !rdy_s_q) |=> in_strobe && !io_bus_o.io_space_select_n)
    else $error("ready did not extend the io cycle");

  vector_target_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL11]
    fire_vec |=> pc_load_o && (pc_target_o == {10'h000, $past(op_i.vec_k), 1'b0}))
    else $error("vector target not twice K");

  load_shift_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // [RL13]
    (fire_load && !sign_extension_mode_bit_i) |=>
      (main_accumulator_o == (ACCUM_W'($past(dm_rdata_i)) << $past(op_i.shift))))
    else $error("unsigned shifted load wrong");

endmodule

/* rtl/dsi_pkg.sv */
// Purpose: shared types and constants for the dsp instruction subset unit
// Assumes: one cpu clock at 100 MHz, active-low asynchronous reset
// Notes:   machine cycle length is a plain default, tune per system
package dsi_pkg;

  localparam int DATA_W          = 16;
  localparam int ACCUM_W         = 32;
  localparam int PC_W            = 16;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MACH_CYCLE_NS   = 40;
  // least time, so round up to whole clocks
  localparam int MACH_CYCLE_CLKS = (MACH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EARLY_PORT_BITS = 3;
  localparam int LATE_PORT_BITS  = 4;
  // data sampled on this clock of the second machine cycle (two-flop sync latency)
  localparam int CAPTURE_CLK     = 1;

  localparam logic               RST_MASK   = 1'b1;
  localparam logic               RST_FORMAT = 1'b0;
  localparam logic [ACCUM_W-1:0] RST_ACCUM  = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  RST_DATA   = 16'h0000;
  localparam logic [PC_W-1:0]    RST_PC     = 16'h0000;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_ENABLE_INT,
    OP_DISABLE_INT,
    OP_SWAP,
    OP_FORMAT,
    OP_IDLE,
    OP_LOW_POWER_HALT,
    OP_PORT_IN,
    OP_SOFT_VECTOR,
    OP_LOAD_SHIFTED,
    OP_LOAD_FROM_BUFFER
  } dsi_opcode_t;

  typedef struct packed {
    dsi_opcode_t                     opcode;
    logic [4:0]                      vec_k;
    logic [3:0]                      shift;
    logic                            fmt_bit;
    logic [LATE_PORT_BITS-1:0]       port_number;
    logic [15:0]                     dm_addr;
  } dsi_op_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        data_enable_strobe_n;
    logic        io_space_select_n;
    logic        external_access_strobe_n;
    logic        read_n;
  } dsi_io_bus_t;

  localparam dsi_io_bus_t IO_QUIET = '{addr: 16'h0000, data_enable_strobe_n: 1'b1,
                                       io_space_select_n: 1'b1, external_access_strobe_n: 1'b1,
                                       read_n: 1'b1};

endpackage

/* testbench/dsi_port_model.sv */
// Purpose: external io port peripheral facing the exec unit pins
// Assumes: shares the cpu clock; one transfer at a time
// Notes:   a released data bus shows the inverted word, never a stale copy
`timescale 1ns/100ps
module dsi_port_model
  import dsi_pkg::*;
(
  // clock
  input  wire logic              sys_clk_i,
  // cpu pins
  input  wire dsi_io_bus_t       io_bus_i,
  output logic [DATA_W-1:0]      port_data_o,
  output logic                   ready_o,
  // bench control
  input  wire logic [DATA_W-1:0] value_i,
  input  wire logic [3:0]        stall_i
);
  logic       sel;
  logic [3:0] hold_q = 4'h0;
  logic [3:0] wait_q = 4'h0;

  assign sel = !io_bus_i.data_enable_strobe_n || !io_bus_i.io_space_select_n;

  always_ff @(posedge sys_clk_i) begin
    hold_q <= sel ? 4'h3 : (hold_q != 4'h0 ? hold_q - 4'h1 : 4'h0);
    wait_q <= sel ? wait_q + {3'h0, wait_q != 4'hf} : 4'h0;
  end

  // word stands while strobed and a short hold after, then goes bad
  assign port_data_o = (sel || hold_q != 4'h0) ? value_i : ~value_i;
  // wait states counted from the first select clock; ready is high otherwise
  assign ready_o = !(!io_bus_i.io_space_select_n && wait_q < stall_i);
endmodule

/* testbench/tb.sv */
// Purpose: self-checking bench for the dsp instruction subset unit
// Assumes: default machine cycle, long enough for ready to pass the synchroniser
// Notes:   ce_i is dropped once to check that a standing request is frozen out
`timescale 1ns/100ps
module tb;
  import dsi_pkg::*;
  localparam int M = MACH_CYCLE_CLKS;
  logic        sys_clk, nrst, ce, op_valid, op_ready, later_gen, sign_extension_mode_bit, irq, int_ack;
  logic        mask, fmt, halted, clk_en, pc_load, dm_we, ready;
  dsi_op_t     op;
  dsi_io_bus_t io;
  logic [31:0] acc, buf_w, e1, e2, lfsr;
  logic [15:0] pc_t, dm_addr, dm_wdata, dm_rdata, pdata, pval, dm_a, r;
  logic [3:0]  stall;
  int          err_count, checks_done, i;

  dsi_exec_unit #(.MC_CLKS(M)) dut (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .ce_i(ce), .op_valid_i(op_valid), .op_i(op),
    .op_ready_o(op_ready), .later_gen_i(later_gen), .sign_extension_mode_bit_i(sign_extension_mode_bit),
    .dm_rdata_i(dm_rdata), .irq_i(irq), .int_ack_o(int_ack), .global_interrupt_mask_o(mask),
    .main_accumulator_o(acc), .accumulator_buffer_o(buf_w), .serial_word_format_bit_o(fmt),
    .halted_o(halted), .func_clk_en_o(clk_en), .pc_load_o(pc_load), .pc_target_o(pc_t),
    .dm_we_o(dm_we), .dm_addr_o(dm_addr), .dm_wdata_o(dm_wdata), .io_bus_o(io),
    .port_data_i(pdata), .ready_i(ready));

  dsi_port_model peer (.sys_clk_i(sys_clk), .io_bus_i(io), .port_data_o(pdata), .ready_o(ready),
    .value_i(pval), .stall_i(stall));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] nxt();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
    return lfsr[15:0];
  endfunction

  function automatic logic [31:0] exp_load(input logic [15:0] d, input logic [3:0] sh, input logic sx);
    logic [31:0] e;
    e = sx ? {{16{d[15]}}, d} : {16'h0000, d};
    return e << sh;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one idle clock before each request so valid never toggles twice in a step
  task automatic run(input dsi_opcode_t c, input logic [15:0] a);
    int n;
    n = 0;
    @(negedge sys_clk);
    op = '{opcode: c, vec_k: a[4:0], shift: a[3:0], fmt_bit: a[0], port_number: a[3:0], dm_addr: dm_a};
    op_valid = 1'b1;
    #1;
    while (op_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100) err_count++;
    @(posedge sys_clk);
    @(negedge sys_clk);
    op_valid = 1'b0;
  endtask

  task automatic port_in(input logic g, input logic [3:0] p, input logic [3:0] s);
    int n;
    n = 0;
    later_gen = g;
    stall = s;
    pval = nxt();
    dm_a = nxt();
    run(OP_PORT_IN, {12'h000, p});
    if (g) begin
      check({io.io_space_select_n, io.external_access_strobe_n, io.read_n}, 3'b000);
      check(io.addr, p);
    end else begin
      check(io.data_enable_strobe_n, 1'b0);
      check(io.addr, p[2:0]);
    end
    while (dm_we !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    // ready reaches the strobe decision two flops late, so a stall of s costs s-1 clocks
    if (g)
      check(n, 2*M + ((s > 4'h1) ? s - 4'h1 : 4'h0));
    else
      check(n, 2*M);
    check(dm_wdata, pval);
    check(dm_addr, dm_a);
    check(io, IO_QUIET);
  endtask

  initial begin
    #100us;
    err_count++;
    finish_test();
  end

  initial begin
    err_count = 0;
    checks_done = 0;
    lfsr = 32'h78d2190a;
    nrst = 1'b0;
    op_valid = 1'b0;
    ce = 1'b1;
    op = '0;
    later_gen = 1'b0;
    sign_extension_mode_bit = 1'b0;
    irq = 1'b0;
    dm_rdata = 16'h0000;
    dm_a = 16'h0000;
    stall = 4'h0;
    pval = 16'h0000;
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    check({mask, fmt, halted, clk_en}, 4'b1001);
    check(acc, 32'h0);
    // interrupt pending while masked, accepted right after enabling
    irq = 1'b1;
    run(OP_ENABLE_INT, 16'h0);
    check(mask, 1'b0);
    check(int_ack, 1'b1);
    // keep the request over the next edge so the interrupt is really taken
    @(negedge sys_clk);
    irq = 1'b0;
    check(mask, 1'b1);
    for (i = 0; i < 2; i++) begin
      run(OP_FORMAT, i[15:0]);
      check(fmt, i[0]);
    end
    // sign bit and widest shift first, then random operands
    for (i = 0; i < 40; i++) begin
      r = nxt();
      dm_rdata = (i < 2) ? 16'h8000 : nxt();
      sign_extension_mode_bit = i[0];
      r[3:0] = (i < 2) ? 4'hf : r[3:0];
      run(OP_LOAD_SHIFTED, r);
      check(acc, exp_load(dm_rdata, r[3:0], sign_extension_mode_bit));
    end
    sign_extension_mode_bit = 1'b1;
    dm_rdata = nxt() | 16'h8000;
    run(OP_LOAD_SHIFTED, 16'h4);
    e1 = exp_load(dm_rdata, 4'h4, 1'b1);
    run(OP_SWAP, 16'h0);
    check(acc, 32'h0);
    run(OP_LOAD_SHIFTED, 16'h0);
    e2 = exp_load(dm_rdata, 4'h0, 1'b1);
    run(OP_SWAP, 16'h0);
    check(acc, e1);
    check(buf_w, e2);
    // frozen enable: a standing swap is not taken and the pair holds
    @(negedge sys_clk);
    ce = 1'b0;
    op.opcode = OP_SWAP;
    op_valid = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(acc, e1);
    check(buf_w, e2);
    op_valid = 1'b0;
    ce = 1'b1;
    run(OP_NOP, 16'h0);
    check(acc, e1);
    run(OP_LOAD_FROM_BUFFER, 16'h0);
    check(acc, e2);
    run(OP_ENABLE_INT, 16'h0);
    check(mask, 1'b0);
    run(OP_DISABLE_INT, 16'h0);
    check(mask, 1'b1);
    for (i = 0; i < 32; i++) begin
      run(OP_SOFT_VECTOR, i[15:0]);
      check(pc_load, 1'b1);
      check(pc_t, 2*i);
    end
    run(OP_IDLE, 16'h0);
    repeat (5) @(negedge sys_clk);
    check({halted, op_ready}, 2'b10);
    irq = 1'b1;
    @(negedge sys_clk);
    irq = 1'b0;
    check(halted, 1'b0);
    // masked request must not wake the low-power halt; only reset does
    run(OP_LOW_POWER_HALT, 16'h0);
    irq = 1'b1;
    repeat (6) @(negedge sys_clk);
    check({halted, clk_en}, 2'b10);
    nrst = 1'b0;
    irq = 1'b0;
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    check({halted, clk_en}, 2'b01);
    run(OP_ENABLE_INT, 16'h0);
    run(OP_LOW_POWER_HALT, 16'h0);
    repeat (4) @(negedge sys_clk);
    check(clk_en, 1'b0);
    irq = 1'b1;
    #1;
    check(int_ack, 1'b1);
    @(negedge sys_clk);
    irq = 1'b0;
    check({halted, clk_en}, 2'b01);
    for (i = 0; i < 16; i++)
      port_in(i >= 8, i[3:0], i[2:0]);
    finish_test();
  end
endmodule
